// ---- hw/smd_pkg.sv ----
// package for the supply margin dac control block: constants, types, states
// assumes a single 20 MHz clock domain and no register bus
//
// Overview of operation
// - six margining dac channels plus a 12-bit readback converter for supervised supplies.
// - effective code is margin code clipped into lower and upper limit inclusive.
// - lower limit above upper limit holds that channel's output buffer high impedance.
// - four selectable ranges; code 0x7F maps to 0.6, 0.8, 1.0 or 1.25 V.
// - output voltage linear: (code - 0x7F)/255 times 0.6015 V plus centre voltage.
// - enabling first powers buffer tracking pin voltage, without driving the pin.
// - after buffer settles, input switches to dac value, then output stage turns on.
// - limits come from non-volatile restore at power-up, before any host access.
package smd_pkg;
    localparam int NUM_CH = 6;
    localparam int CODE_W = 8;
    localparam int ADC_W = 12;
    localparam int CH_SEL_W = 3;
    localparam logic [7:0] MID_CODE = 8'h7F;
    localparam logic [7:0] LOWER_LIMIT_RST = 8'h00;
    localparam logic [7:0] UPPER_LIMIT_RST = 8'hFF;
    localparam logic [7:0] MARGIN_CODE_RST = 8'h7F;
    localparam logic [1:0] RANGE_RST = 2'h0;
    // range centre voltages in millivolts
    localparam int CENTRE_MV_0 = 600;
    localparam int CENTRE_MV_1 = 800;
    localparam int CENTRE_MV_2 = 1000;
    localparam int CENTRE_MV_3 = 1250;
    // full span in microvolts across 255 codes
    localparam int SPAN_UV = 601500;
    localparam int CODE_STEPS = 255;
    // buffer settle and input switch times
    localparam int CLK_MHZ = 20;
    localparam int SETTLE_NS = 10000;
    localparam int SWITCH_NS = 1000;
    localparam int SETTLE_CYC = (SETTLE_NS * CLK_MHZ + 999) / 1000;
    localparam int SWITCH_CYC = (SWITCH_NS * CLK_MHZ + 999) / 1000;
    localparam int TMR_W = 16;
    // comparator synchroniser depth each trial waits out, and start-to-done edges
    localparam int ADC_WAIT = 2;
    localparam int ADC_CYC = ADC_W * (ADC_WAIT + 1);

    typedef enum logic [3:0] {
        BUF_OFF = 4'b0001,
        BUF_TRACK = 4'b0010,
        BUF_SWITCH = 4'b0100,
        BUF_DRIVE = 4'b1000
    } smd_buf_e;

    typedef struct packed {
        logic [7:0] margin_code;
        logic [7:0] lower_code_limit;
        logic [7:0] upper_code_limit;
        logic [1:0] range_sel;
        logic enable;
    } smd_cfg_s;

    typedef struct packed {
        logic [7:0] code;
        logic [1:0] range_sel;
        logic power;
        logic input_dac;
        logic out_stage;
    } smd_drv_s;

    // millivolt centre for a range select, used per channel
    function automatic logic [10:0] centre_mv(input logic [1:0] sel);
        case (sel)
            2'h0: centre_mv = 11'(CENTRE_MV_0);
            2'h1: centre_mv = 11'(CENTRE_MV_1);
            2'h2: centre_mv = 11'(CENTRE_MV_2);
            default: centre_mv = 11'(CENTRE_MV_3);
        endcase
    endfunction : centre_mv
endpackage : smd_pkg

// ---- hw/smd_chan.sv ----
// one margining dac channel: clipping, tri-state guard and power-up sequencer
// assumes configuration arrives from the same clock domain
`timescale 1ns/1ns
module smd_chan (
    // clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // configuration
    input smd_pkg::smd_cfg_s cfg,
    // analogue drive
    output smd_pkg::smd_drv_s drv,
    output logic [10:0] target_mv,
    output logic limits_inverted
);
    smd_pkg::smd_buf_e state_q, state_d;
    logic [smd_pkg::TMR_W-1:0] tmr_q, tmr_d;
    smd_pkg::smd_drv_s drv_d;
    logic [7:0] clip_code;
    logic inverted;
    logic go;
    logic [10:0] tgt_d;
    logic signed [9:0] offs;
    logic signed [31:0] delta_uv;

    assign clip_code = (cfg.margin_code < cfg.lower_code_limit) ? cfg.lower_code_limit :
                       (cfg.margin_code > cfg.upper_code_limit) ? cfg.upper_code_limit :
                       cfg.margin_code;
    assign inverted = cfg.lower_code_limit > cfg.upper_code_limit;
    // inverted limits act as a disable, so the sequence restarts once fixed
    assign go = cfg.enable && !inverted;
    assign offs = 10'(signed'({2'b00, clip_code})) - 10'(signed'({2'b00, smd_pkg::MID_CODE}));
    assign delta_uv = (32'(offs) * smd_pkg::SPAN_UV) / smd_pkg::CODE_STEPS;
    // signed sum, so codes below mid scale pull the centre down
    assign tgt_d = 11'(int'(smd_pkg::centre_mv(cfg.range_sel)) + delta_uv / 1000);

    always_comb begin
        state_d = state_q;
        tmr_d = tmr_q;
        if (!go) begin
            state_d = smd_pkg::BUF_OFF;
            tmr_d = '0;
        end else begin
            case (state_q)
                smd_pkg::BUF_OFF: begin
                    state_d = smd_pkg::BUF_TRACK;
                    tmr_d = smd_pkg::TMR_W'(smd_pkg::SETTLE_CYC - 1);
                end
                smd_pkg::BUF_TRACK: begin
                    if (tmr_q == '0) begin
                        state_d = smd_pkg::BUF_SWITCH;
                        tmr_d = smd_pkg::TMR_W'(smd_pkg::SWITCH_CYC - 1);
                    end else begin
                        tmr_d = tmr_q - 1'b1;
                    end
                end
                smd_pkg::BUF_SWITCH: begin
                    if (tmr_q == '0) begin
                        state_d = smd_pkg::BUF_DRIVE;
                    end else begin
                        tmr_d = tmr_q - 1'b1;
                    end
                end
                smd_pkg::BUF_DRIVE: state_d = smd_pkg::BUF_DRIVE;
                default: state_d = smd_pkg::BUF_OFF;
            endcase
        end
    end

    // drive bits decoded from the next state so outputs stay registered
    assign drv_d.code = clip_code;
    assign drv_d.range_sel = cfg.range_sel;
    assign drv_d.power = state_d != smd_pkg::BUF_OFF;
    assign drv_d.input_dac = (state_d == smd_pkg::BUF_SWITCH) ||
                             (state_d == smd_pkg::BUF_DRIVE);
    assign drv_d.out_stage = state_d == smd_pkg::BUF_DRIVE;

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            state_q <= smd_pkg::BUF_OFF;
            tmr_q <= '0;
            drv <= '0;
            target_mv <= '0;
            limits_inverted <= 1'b0;
        end else begin
            state_q <= state_d;
            tmr_q <= tmr_d;
            drv <= drv_d;
            target_mv <= tgt_d;
            limits_inverted <= inverted;
        end
    end
endmodule : smd_chan

// ---- hw/smd_top.sv ----
// supply margin dac control: six channels, limit restore and readback converter
// assumes restore data arrive from a non-volatile loader; comparator is a pin
`timescale 1ns/1ns
module smd_top (
    // clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // non-volatile restore of lower and upper limits
    input wire logic restore_valid,
    input wire logic [2:0] restore_ch,
    input wire logic [7:0] restore_lower,
    input wire logic [7:0] restore_upper,
    input wire logic restore_done,
    // host controls
    input wire logic host_wr,
    input wire logic [2:0] host_ch,
    input wire logic [7:0] host_margin_code,
    input wire logic [1:0] host_range,
    input wire logic host_enable,
    input wire logic host_lim_wr,
    input wire logic [7:0] host_lower,
    input wire logic [7:0] host_upper,
    // readback converter control
    input wire logic adc_start,
    input wire logic [3:0] adc_input_sel,
    input wire logic adc_cmp_pin,
    output logic [3:0] adc_mux_sel,
    output logic [11:0] adc_trial,
    output logic [11:0] adc_result,
    output logic adc_busy,
    output logic adc_done,
    // status
    output logic config_ready,
    output logic [5:0] ch_limits_inverted,
    // analogue drive
    output smd_pkg::smd_drv_s [5:0] ch_drv,
    output logic [5:0][10:0] ch_target_mv
);
    smd_pkg::smd_cfg_s [5:0] cfg_q;
    logic ready_q;
    logic cmp_meta_q, cmp_sync_q;
    logic [3:0] bit_q;
    logic [11:0] sar_q;

    // limits restored before host access; host writes refused until ready
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            ready_q <= 1'b0;
        end else if (restore_done) begin
            ready_q <= 1'b1;
        end
    end
    assign config_ready = ready_q;

    // channel select match, shared by the restore and both host strobes
    function automatic logic ch_match(input logic [2:0] sel, input int idx);
        ch_match = (sel == 3'(idx));
    endfunction : ch_match

    genvar g;
    generate
        for (g = 0; g < smd_pkg::NUM_CH; g++) begin : g_ch
            logic rst_hit, host_hit, lim_hit;
            assign rst_hit = restore_valid && !ready_q && ch_match(restore_ch, g);
            assign host_hit = host_wr && ready_q && ch_match(host_ch, g);
            assign lim_hit = host_lim_wr && ready_q && ch_match(host_ch, g);
            always_ff @(posedge mclk or posedge sys_rst) begin
                if (sys_rst) begin
                    cfg_q[g].margin_code <= smd_pkg::MARGIN_CODE_RST;
                    cfg_q[g].range_sel <= smd_pkg::RANGE_RST;
                    cfg_q[g].enable <= 1'b0;
                    // reset leaves limits inverted so no buffer drives before restore
                    cfg_q[g].lower_code_limit <= smd_pkg::UPPER_LIMIT_RST;
                    cfg_q[g].upper_code_limit <= smd_pkg::LOWER_LIMIT_RST;
                end else begin
                    if (rst_hit) begin
                        cfg_q[g].lower_code_limit <= restore_lower;
                        cfg_q[g].upper_code_limit <= restore_upper;
                    end else if (lim_hit) begin
                        cfg_q[g].lower_code_limit <= host_lower;
                        cfg_q[g].upper_code_limit <= host_upper;
                    end
                    if (host_hit) begin
                        cfg_q[g].margin_code <= host_margin_code;
                        cfg_q[g].range_sel <= host_range;
                        cfg_q[g].enable <= host_enable;
                    end
                end
            end
            smd_chan u_chan (
                .mclk(mclk),
                .sys_rst(sys_rst),
                .cfg(cfg_q[g]),
                .drv(ch_drv[g]),
                .target_mv(ch_target_mv[g]),
                .limits_inverted(ch_limits_inverted[g])
            );
        end
    endgenerate

    // comparator pin is asynchronous to mclk
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            cmp_meta_q <= 1'b0;
            cmp_sync_q <= 1'b0;
        end else begin
            cmp_meta_q <= adc_cmp_pin;
            cmp_sync_q <= cmp_meta_q;
        end
    end

    // successive approximation, msb first; comparator high keeps the trial bit.
    // each trial waits out both synchroniser stages before its bit is decided,
    // otherwise the decision would use the comparator answer for an older trial
    logic [11:0] bit_mask;
    logic [11:0] kept;
    logic [11:0] next_trial;
    logic [1:0] wait_q;
    logic decide;
    assign bit_mask = 12'h001 << bit_q;
    assign kept = cmp_sync_q ? sar_q : (sar_q & ~bit_mask);
    assign next_trial = (bit_q == 4'h0) ? kept : (kept | (bit_mask >> 1));
    assign decide = adc_busy && (wait_q == 2'h0);

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            bit_q <= 4'h0;
            wait_q <= 2'h0;
            sar_q <= 12'h000;
            adc_busy <= 1'b0;
            adc_done <= 1'b0;
            adc_result <= 12'h000;
            adc_trial <= 12'h000;
            adc_mux_sel <= 4'h0;
        end else begin
            adc_done <= 1'b0;
            if (!adc_busy && adc_start && ready_q) begin
                adc_busy <= 1'b1;
                adc_mux_sel <= adc_input_sel;
                bit_q <= 4'(smd_pkg::ADC_W - 1);
                wait_q <= 2'(smd_pkg::ADC_WAIT);
                sar_q <= 12'h800;
                adc_trial <= 12'h800;
            end else if (decide) begin
                sar_q <= next_trial;
                adc_trial <= next_trial;
                wait_q <= 2'(smd_pkg::ADC_WAIT);
                if (bit_q == 4'h0) begin
                    adc_busy <= 1'b0;
                    adc_done <= 1'b1;
                    adc_result <= kept;
                end else begin
                    bit_q <= bit_q - 4'h1;
                end
            end else if (adc_busy) begin
                wait_q <= wait_q - 2'h1;
            end
        end
    end
endmodule : smd_top

// ---- testbench/smd_top_properties.sv ----
// checker for smd_top: power-up order, tri-state guard and readback timing
// assumes binding onto smd_top, one clock domain
`timescale 1ns/1ns
module smd_top_checker (
    // clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // readback
    input wire logic adc_start,
    input wire logic adc_busy,
    input wire logic adc_done,
    // status and drive
    input wire logic config_ready,
    input wire logic [5:0] ch_limits_inverted,
    input wire smd_pkg::smd_drv_s [5:0] ch_drv,
    input wire logic [5:0][10:0] ch_target_mv
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);
    sequence s_switch;
        ch_drv[0].input_dac && !ch_drv[0].out_stage;
    endsequence
    sequence s_adc_go;
        adc_start && !adc_busy && config_ready;
    endsequence
    property p_tri; ch_limits_inverted[0] |-> !ch_drv[0].out_stage; endproperty
    a_tri: assert property (p_tri) else $error("drive with inverted limits");
    property p_track; $rose(ch_drv[0].input_dac) |-> $past(ch_drv[0].power, 8); endproperty
    a_track: assert property (p_track) else $error("input switched too early");
    property p_switch; s_switch ##1 ch_drv[0].out_stage |-> $past(ch_drv[0].input_dac, 8); endproperty
    a_switch: assert property (p_switch) else $error("output stage too early");
    property p_chain; ch_drv[0].out_stage |-> ch_drv[0].input_dac && ch_drv[0].power; endproperty
    a_chain: assert property (p_chain) else $error("stage order broken");
    property p_ready; !config_ready |-> !ch_drv[0].power; endproperty
    a_ready: assert property (p_ready) else $error("buffer on before restore");
    property p_adc; s_adc_go |-> ##37 adc_done; endproperty
    a_adc: assert property (p_adc) else $error("conversion late");
    property p_busy; s_adc_go |=> adc_busy [*8]; endproperty
    a_busy: assert property (p_busy) else $error("busy dropped");
    property p_done; adc_done |-> !adc_busy ##1 !adc_done; endproperty
    a_done: assert property (p_done) else $error("done not a pulse");
    property p_mid;
        ch_drv[0].code == 8'h7F && ch_drv[0].range_sel == 2'h3 |-> ch_target_mv[0] == 11'h4E2;
    endproperty
    a_mid: assert property (p_mid) else $error("mid code off centre");
endmodule : smd_top_checker
bind smd_top smd_top_checker u_smd_top_checker (.mclk(mclk), .sys_rst(sys_rst),
    .adc_start(adc_start), .adc_busy(adc_busy), .adc_done(adc_done),
    .config_ready(config_ready), .ch_limits_inverted(ch_limits_inverted),
    .ch_drv(ch_drv), .ch_target_mv(ch_target_mv));

// ---- testbench/smd_conv_model.sv ----
// readback comparator model: supply level against the trial word
// assumes the level is held steady for a whole conversion
`timescale 1ns/1ns
module smd_conv_model (
    // trial word and supply level
    input wire logic [11:0] adc_trial,
    input wire logic [11:0] level,
    // comparator output
    output logic adc_cmp_pin
);
    // ideal, no offset; latency lives in the design's synchroniser
    assign adc_cmp_pin = (level >= adc_trial);
endmodule : smd_conv_model

// ---- testbench/tb_smd_top.sv ----
// testbench for smd_top: restore, host writes, clipping, power-up, readback
// assumes the comparator model and the bound checker are compiled alongside
`timescale 1ns/1ns
module tb_smd_top;
    logic mclk = 1'b0;
    logic sys_rst = 1'b1;
    logic restore_valid = 1'b0, restore_done = 1'b0, host_wr = 1'b0, host_enable = 1'b0;
    logic host_lim_wr = 1'b0, adc_start = 1'b0, adc_cmp_pin;
    logic [2:0] restore_ch = 3'h0, host_ch = 3'h0;
    logic [7:0] restore_lower = 8'h00, restore_upper = 8'h00, host_margin_code = 8'h00;
    logic [7:0] host_lower = 8'h00, host_upper = 8'h00;
    logic [1:0] host_range = 2'h0;
    logic [3:0] adc_input_sel = 4'h0, adc_mux_sel;
    logic [11:0] level = 12'h000, adc_trial, adc_result;
    logic adc_busy, adc_done, config_ready;
    logic [5:0] ch_limits_inverted;
    smd_pkg::smd_drv_s [5:0] ch_drv;
    logic [5:0][10:0] ch_target_mv;
    logic [7:0] codes [5] = '{8'h05, 8'h10, 8'h80, 8'hF0, 8'hFF};
    logic [10:0] centre [4] = '{11'h258, 11'h320, 11'h3E8, 11'h4E2};
    logic [7:0] e;
    int errors = 0, comparisons = 0, n;
    wire [3:0] flags = {adc_done, ch_drv[0].out_stage, ch_drv[0].input_dac, ch_drv[0].power};
    always #25 mclk = ~mclk;
    smd_top u_smd_top (.mclk, .sys_rst, .restore_valid, .restore_ch, .restore_lower,
        .restore_upper, .restore_done, .host_wr, .host_ch, .host_margin_code, .host_range,
        .host_enable, .host_lim_wr, .host_lower, .host_upper, .adc_start, .adc_input_sel,
        .adc_cmp_pin, .adc_mux_sel, .adc_trial, .adc_result, .adc_busy, .adc_done,
        .config_ready, .ch_limits_inverted, .ch_drv, .ch_target_mv);
    smd_conv_model u_smd_conv_model (.adc_trial, .level, .adc_cmp_pin);
    task automatic report_and_stop();
        if (errors == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : report_and_stop
    task automatic chk(input logic [11:0] got, input logic [11:0] exp);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic tick(input int k);
        repeat (k) @(negedge mclk);
    endtask : tick
    // bounded wait on one flag; n counts the cycles taken
    task automatic wait_bit(input int b);
        n = 0;
        while (flags[b] !== 1'b1) begin
            tick(1);
            n++;
            if (n > 400) begin
                errors++;
                $display("BAD %0t timeout", $time);
                report_and_stop();
            end
        end
    endtask : wait_bit
    task automatic restore(input logic [2:0] ch, input logic [7:0] lo, input logic [7:0] up);
        restore_ch = ch;
        restore_lower = lo;
        restore_upper = up;
        restore_valid = 1'b1;
        tick(1);
        restore_valid = 1'b0;
        tick(1);
    endtask : restore
    task automatic host_set(input logic [2:0] ch, input logic [7:0] c, input logic [1:0] r,
        input logic en);
        host_ch = ch;
        host_margin_code = c;
        host_range = r;
        host_enable = en;
        host_wr = 1'b1;
        tick(1);
        host_wr = 1'b0;
    endtask : host_set
    task automatic lim(input logic [2:0] ch, input logic [7:0] lo, input logic [7:0] up);
        host_ch = ch;
        host_lower = lo;
        host_upper = up;
        host_lim_wr = 1'b1;
        tick(1);
        host_lim_wr = 1'b0;
    endtask : lim
    initial begin
        tick(10);
        sys_rst = 1'b0;
        tick(1);
        chk(12'(ch_limits_inverted), 12'h03F);
        host_set(3'h1, 8'h00, 2'h0, 1'b1);
        for (int c = 0; c < 6; c++) begin
            restore(3'(c), 8'h10, 8'hF0);
        end
        restore_done = 1'b1;
        tick(1);
        restore_done = 1'b0;
        restore(3'h1, 8'h00, 8'hFF);
        tick(1);
        chk(12'(config_ready), 12'h001);
        chk(12'(ch_limits_inverted), 12'h000);
        chk(12'(ch_drv[1].code), 12'h07F);
        chk(12'(ch_drv[1].power), 12'h000);
        for (int r = 0; r < 4; r++) begin
            host_set(3'h1, 8'h7F, 2'(r), 1'b0);
            tick(1);
            chk(12'(ch_target_mv[1]), 12'(centre[r]));
            chk(12'(ch_drv[1].range_sel), 12'(r));
        end
        // clip against 10..F0, then the linear target at the 1.25 V centre
        for (int i = 0; i < 5; i++) begin
            host_set(3'h1, codes[i], 2'h3, 1'b0);
            tick(1);
            e = (codes[i] < 8'h10) ? 8'h10 : (codes[i] > 8'hF0) ? 8'hF0 : codes[i];
            chk(12'(ch_drv[1].code), 12'(e));
            chk(12'(ch_target_mv[1]), 12'(1250 + ((int'(e) - 127) * 6015) / 2550));
        end
        host_set(3'h0, 8'h7F, 2'h3, 1'b1);
        tick(1);
        chk(12'(flags[2:0]), 12'h001);
        wait_bit(1);
        chk(12'(n > 195 && n < 203 && flags[2] == 1'b0), 12'h001);
        wait_bit(2);
        chk(12'(n > 16 && n < 24), 12'h001);
        lim(3'h0, 8'h80, 8'h70);
        tick(1);
        chk(12'(flags[2:0]), 12'h000);
        chk(12'(ch_limits_inverted), 12'h001);
        host_set(3'h0, 8'h7F, 2'h0, 1'b0);
        lim(3'h0, 8'h00, 8'hFF);
        tick(2);
        chk(12'(flags[2:0]), 12'h000);
        for (int k = 0; k < 3; k++) begin
            level = (k == 0) ? 12'hFFF : (k == 1) ? 12'h000 : 12'h5A3;
            adc_input_sel = 4'(k + 5);
            adc_start = 1'b1;
            tick(2);
            adc_start = 1'b0;
            chk(12'(adc_mux_sel), 12'(k + 5));
            wait_bit(3);
            chk(12'(n > 33 && n < 37), 12'h001);
            chk(adc_result, level);
        end
        report_and_stop();
    end
endmodule : tb_smd_top
